// File: rtl/sss_pkg.sv
package sss_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int PAR_BASE = 32;
  localparam int DEPTH = 131072;
  localparam int STEP_W = 2;
  localparam logic [STEP_W-1:0] STEP_ZERO = 2'h0;
  localparam logic [STEP_W-1:0] STEP_ONE = 2'h1;

  // Access kind held for the burst in progress
  typedef enum logic [2:0] {
    SSS_IDLE = 3'h1,
    SSS_READ = 3'h2,
    SSS_WRITE = 3'h4
  } sss_acc_t;

  // Whole state of the control path
  typedef struct packed {
    sss_acc_t acc;
    logic [ADDR_W-1:0] base;
    logic [STEP_W-1:0] step;
    logic ph_valid;
    logic ph_write;
    logic [ADDR_W-1:0] ph_addr;
    logic [LANES-1:0] ph_be;
    logic drv;
  } sss_state_t;

  localparam sss_state_t STATE_RST = '{
    acc: SSS_IDLE, base: '0, step: STEP_ZERO, ph_valid: 1'b0,
    ph_write: 1'b0, ph_addr: '0, ph_be: '0, drv: 1'b0};

  // Low address bits of a burst word
  function automatic logic [STEP_W-1:0] burst_lo(input logic [STEP_W-1:0] start,
                                                 input logic [STEP_W-1:0] step,
                                                 input logic interleave);
    burst_lo = interleave ? (start ^ step) : STEP_W'(start + step);
  endfunction
endpackage

// File: rtl/sss_array.sv
`timescale 1ns/1ps
module sss_array (
  input wire logic clk_sys, // Clock
  input wire logic we, // Write strobe
  input wire logic re, // Read strobe
  input wire logic [sss_pkg::LANES-1:0] be, // Lane enables
  input wire logic [sss_pkg::ADDR_W-1:0] addr, // Word address
  input wire logic [sss_pkg::DATA_W-1:0] wdata, // Write word
  output logic [sss_pkg::DATA_W-1:0] rdata_r // Read word, registered
);
  import sss_pkg::*;

  logic [DATA_W-1:0] mem [DEPTH];

  // Each lane is eight data bits plus its parity bit
  always_ff @(posedge clk_sys) begin
    if (we) begin
      for (int k = 0; k < LANES; k++) begin
        if (be[k]) begin
          mem[addr][k*LANE_W +: LANE_W] <= wdata[k*LANE_W +: LANE_W];
          mem[addr][PAR_BASE+k] <= wdata[PAR_BASE+k];
        end
      end
    end
    if (re) begin
      rdata_r <= mem[addr];
    end
  end
endmodule

// File: rtl/sss_top.sv
`timescale 1ns/1ps
// Functional notes
// - Selected only with both lows low, high high
// - High select acts like lows, inverted
// - Unselected with load low starts deselect
// - Bus released one cycle after deselect
// - Everything but output enable timed on rising clock edge
// - Write data and parity captured at edge
// - Read data flows to pins unregistered
// - Burst order high interleaved, low linear
// - Output enable high floats bus immediately
// - Load low loads, high advances counter
// - Access type set at load, data next cycle
// - Clock gate high freezes all but output enable
// - Counter steps two low bits, wraps
module sss_top (
  input wire logic clk_sys, // 40 MHz clock
  input wire logic rst_n, // Sync reset, low
  input wire logic [sss_pkg::ADDR_W-1:0] addr, // Address pins
  input wire logic select_low_a_n, // Chip select, low
  input wire logic select_low_b_n, // Second chip select, low
  input wire logic select_high_b, // Chip select, high
  input wire logic advance_or_load, // High advance, low load
  input wire logic read_not_write, // High read, low write
  input wire logic clock_gate_n, // High suspends the edge
  input wire logic [sss_pkg::LANES-1:0] byte_wr_n, // Lane write enables, low
  input wire logic burst_order_sel, // High interleaved
  input wire logic out_en_n, // Async output enable, low
  input wire logic [sss_pkg::DATA_W-1:0] dq_in, // Data and parity pins in
  output logic [sss_pkg::DATA_W-1:0] dq_out, // Data and parity pins out
  output logic dq_oe // High while driving pins
);
  import sss_pkg::*;

  sss_state_t st_r;
  sss_state_t st_nxt;
  logic sel;
  logic run;
  logic [DATA_W-1:0] rdata;
  logic [STEP_W-1:0] step_up;

  // All three selects must be true at once
  assign sel = !select_low_a_n && !select_low_b_n && select_high_b;
  // A gated edge must not touch the array either
  assign run = !clock_gate_n;
  assign step_up = STEP_W'(st_r.step + STEP_ONE);

  // Next state; loads, bursts, deselects and no-ops
  always_comb begin
    st_nxt = st_r;
    if (run) begin
      st_nxt.drv = st_r.ph_valid && !st_r.ph_write;
      if (!advance_or_load && sel) begin
        st_nxt.acc = read_not_write ? SSS_READ : SSS_WRITE;
        st_nxt.base = addr;
        st_nxt.step = STEP_ZERO;
        st_nxt.ph_valid = 1'b1;
        st_nxt.ph_write = !read_not_write;
        st_nxt.ph_addr = addr;
        st_nxt.ph_be = ~byte_wr_n;
      end else if (!advance_or_load) begin
        st_nxt.acc = SSS_IDLE;
        st_nxt.ph_valid = 1'b0;
        st_nxt.ph_write = 1'b0;
      end else if (st_r.acc != SSS_IDLE) begin
        // External address ignored; type kept from the load
        st_nxt.step = step_up;
        st_nxt.ph_valid = 1'b1;
        st_nxt.ph_write = (st_r.acc == SSS_WRITE);
        st_nxt.ph_addr = {st_r.base[ADDR_W-1:STEP_W],
                          burst_lo(st_r.base[STEP_W-1:0], step_up, burst_order_sel)};
        st_nxt.ph_be = ~byte_wr_n;
      end else begin
        st_nxt.ph_valid = 1'b0;
        st_nxt.ph_write = 1'b0;
      end
    end
  end

  // State register, rising edge only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Array write takes the pins at the data edge; read word lands in its register
  sss_array u_array (
    .clk_sys(clk_sys),
    .we(run && st_r.ph_valid && st_r.ph_write),
    .re(run && st_r.ph_valid && !st_r.ph_write),
    .be(st_r.ph_be),
    .addr(st_r.ph_addr),
    .wdata(dq_in),
    .rdata_r(rdata)
  );

  // No output register; enable gated without the clock so it floats at once
  assign dq_out = rdata;
  assign dq_oe = st_r.drv && !out_en_n;

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      clock_gate_n |=> $stable(st_r) && $stable(dq_out);
  endproperty

  sel_deselect_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && !advance_or_load && !sel |=> !st_r.ph_valid && st_r.acc == SSS_IDLE)
    else $error("deselect did not end access");
  high_select_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && !advance_or_load && !select_high_b |=> !st_r.ph_valid)
    else $error("high select low still loaded");
  all_select_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && !advance_or_load && !select_low_a_n && !select_low_b_n && select_high_b
    |=> st_r.ph_valid)
    else $error("selected load not taken");
  desel_latency_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && !advance_or_load && !sel ##1 run |=> !dq_oe)
    else $error("bus not released after deselect");
  load_phase_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && !advance_or_load && sel
    |=> st_r.ph_addr == $past(addr) && st_r.ph_write == !$past(read_not_write))
    else $error("load address or type wrong");
  // Drive flag only; the enable pin may move on its own afterwards
  read_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && !advance_or_load && sel && read_not_write ##1 run && !out_en_n
    |=> st_r.drv)
    else $error("read data not driven one cycle after load");
  suspend_hold_a: assert property (p_hold)
    else $error("state moved while suspended");
  oe_float_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    out_en_n |-> !dq_oe)
    else $error("driving with output enable high");
  write_float_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && st_r.ph_valid && st_r.ph_write |=> !dq_oe)
    else $error("driving during write data phase");
  linear_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && advance_or_load && !burst_order_sel && st_r.acc != SSS_IDLE
    |=> st_r.ph_addr[STEP_W-1:0] == STEP_W'($past(st_r.ph_addr[STEP_W-1:0]) + STEP_ONE))
    else $error("linear burst step wrong");
  inter_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && advance_or_load && burst_order_sel && st_r.acc != SSS_IDLE
    |=> st_r.ph_addr[STEP_W-1:0] == (st_r.base[STEP_W-1:0] ^ st_r.step))
    else $error("interleaved burst step wrong");

  // Counter goes back to the first word after the fourth
  step_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && advance_or_load && st_r.acc != SSS_IDLE && &st_r.step
    |=> st_r.step == STEP_ZERO)
    else $error("burst counter did not wrap");

  // Advancing keeps the loaded base and access kind
  adv_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && advance_or_load && st_r.acc != SSS_IDLE
    |=> st_r.base == $past(st_r.base) && st_r.acc == $past(st_r.acc))
    else $error("advance disturbed the loaded burst");

  // Advance with no burst running is a no-op
  noop_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && advance_or_load && st_r.acc == SSS_IDLE |=> !st_r.ph_valid)
    else $error("no-op started a data phase");

  // Burst words keep the type chosen at the load
  burst_type_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && advance_or_load && st_r.acc != SSS_IDLE
    |=> st_r.ph_write == ($past(st_r.acc) == SSS_WRITE))
    else $error("burst word changed access type");

  // A deselect still lets the pending data phase finish
  desel_pending_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && !advance_or_load && !sel
    |=> st_r.drv == $past(st_r.ph_valid && !st_r.ph_write))
    else $error("deselect cut the pending data phase");

  // Gated edge must leave the array alone as well
  gate_array_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clock_gate_n |-> !u_array.we && !u_array.re)
    else $error("array touched on a gated edge");

  // Lane zero and its parity reach the array at the data edge
  lane_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && st_r.ph_valid && st_r.ph_write && st_r.ph_be[0]
    ##1 run && st_r.ph_valid && !st_r.ph_write && st_r.ph_addr == $past(st_r.ph_addr)
    |=> rdata[LANE_W-1:0] == $past(dq_in[LANE_W-1:0], 2)
        && rdata[PAR_BASE] == $past(dq_in[PAR_BASE], 2))
    else $error("written lane not read back");

  // Pins show the array word straight after the data edge
  flow_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && st_r.ph_valid && !st_r.ph_write
    |=> dq_out == u_array.mem[$past(st_r.ph_addr)])
    else $error("read word not on the pins");

  // Bus stays quiet while reset is held; no disable here on purpose
  reset_quiet_a: assert property (@(posedge clk_sys)
    !rst_n |=> !dq_oe)
    else $error("bus driven out of reset");

  load_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    run && !advance_or_load && sel && read_not_write ##1 run && advance_or_load ##1 dq_oe);
  burst_write_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    st_r.acc == SSS_WRITE && st_r.step == 2'h3);
  deselect_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    dq_oe ##1 run && !advance_or_load && !sel ##1 dq_oe ##1 !dq_oe);
  inter_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    burst_order_sel && st_r.acc == SSS_READ && &st_r.step);
  gated_burst_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    clock_gate_n && st_r.acc != SSS_IDLE ##1 !clock_gate_n);
endmodule

// File: dv/sss_master.sv
`timescale 1ns/1ps
// Far-side master; pins move only just after a rising edge
module sss_master (
  input wire logic clk_sys, // Clock
  output logic [63:0] pins // Addr, selects, controls, lanes, oe_n, data
);
  // Each command holds until the next one replaces it
  task automatic op(input logic [63:0] p);
    @(posedge clk_sys);
    pins <= p;
  endtask
  // Start deselected with output enable low
  initial begin
    pins = {17'h0, 3'b101, 44'h0};
  end
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import sss_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic order_sel = 1'b0;
  logic oe_lvl = 1'b0;
  logic [63:0] pins;
  logic [ADDR_W-1:0] addr, pa, base;
  logic [2:0] sel;
  logic adv, rnw, gate_n, oe_n, dq_oe;
  logic pv = 1'b0, pw = 1'b0, drv = 1'b0, busy = 1'b0, bwr = 1'b0;
  logic [LANES-1:0] bw_n, pb;
  logic [DATA_W-1:0] din, dq_out, od;
  logic [DATA_W:0] ev;
  logic [1:0] step;
  logic [2:0] dsel [3] = '{3'h5, 3'h3, 3'h0};
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W:0] exp_q [$];
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  assign {addr, sel, adv, rnw, gate_n, bw_n, oe_n, din} = pins;
  sss_master sss_master_inst (.clk_sys(clk_sys), .pins(pins));
  sss_top sss_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
    .select_low_a_n(sel[2]), .select_low_b_n(sel[1]), .select_high_b(sel[0]),
    .advance_or_load(adv), .read_not_write(rnw), .clock_gate_n(gate_n),
    .byte_wr_n(bw_n), .burst_order_sel(order_sel), .out_en_n(oe_n), .dq_in(din),
    .dq_out(dq_out), .dq_oe(dq_oe));
  always #12.5 clk_sys = ~clk_sys;
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One edge of the reference pipeline per command; a gated edge keeps everything
  task automatic cmd(input logic [ADDR_W-1:0] a, input logic [2:0] s, input logic ad,
                     input logic rw, input logic g, input logic [LANES-1:0] bw);
    logic [DATA_W-1:0] d;
    d = {$urandom, $urandom};
    sss_master_inst.op({a, s, ad, rw, g, bw, oe_lvl, d});
    if (!g) begin
      for (int k = 0; k < LANES; k++) if (pv && pw && !pb[k]) begin
        mem[pa][k*LANE_W +: LANE_W] = d[k*LANE_W +: LANE_W];
        mem[pa][PAR_BASE+k] = d[PAR_BASE+k];
      end
      if (pv && !pw) od = mem[pa];
      drv = pv && !pw;
      if (!ad) begin
        busy = (s == 3'h1);
        bwr = !rw;
        base = a;
        step = 2'h0;
      end else step = step + 2'h1;
      pv = busy;
      pw = bwr;
      pb = bw;
      pa = {base[ADDR_W-1:2], order_sel ? base[1:0] ^ step : base[1:0] + step};
    end
    exp_q.push_back({drv, od});
  endtask
  task automatic ld(input logic [ADDR_W-1:0] a, input logic rw);
    cmd(a, 3'h1, 1'b0, rw, 1'b0, 4'h0);
  endtask
  task automatic nx(input int n);
    repeat (n) cmd('0, 3'h1, 1'b1, 1'b0, 1'b0, 4'h0);
  endtask
  // Outputs are settled a little after each edge
  always @(posedge clk_sys) begin
    #1;
    if (exp_q.size() > 1) begin
      ev = exp_q.pop_front();
      check(DATA_W'(dq_oe), DATA_W'(ev[DATA_W] & ~oe_n));
      if (ev[DATA_W] && !oe_n) check(dq_out, ev[DATA_W-1:0]);
    end
  end
  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h195cdab4));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    ld(17'h10, 1'b0);
    nx(3);
    ld(17'h12, 1'b1);
    nx(4);
    $display("Test linear burst done");
    foreach (dsel[i]) begin
      ld(17'h10, 1'b1);
      cmd('0, dsel[i], 1'b0, 1'b1, 1'b0, 4'h0);
      nx(2);
    end
    $display("Test deselect done");
    for (int k = 0; k < LANES; k++) cmd(17'h11, 3'h1, 1'b0, 1'b0, 1'b0, ~(4'h1 << k));
    ld(17'h11, 1'b1);
    cmd('0, 3'h1, 1'b1, 1'b0, 1'b1, 4'h0);
    cmd('0, 3'h1, 1'b1, 1'b0, 1'b1, 4'h0);
    nx(2);
    $display("Test lanes and gate done");
    oe_lvl = 1'b1;
    nx(2);
    oe_lvl = 1'b0;
    cmd('0, 3'h0, 1'b0, 1'b0, 1'b0, 4'h0);
    order_sel <= 1'b1;
    ld(17'h11, 1'b1);
    nx(5);
    $display("Test interleaved done");
    repeat (80) cmd({15'h4, 2'($urandom)}, ($urandom % 3) ? 3'h1 : dsel[$urandom % 3],
      1'($urandom), 1'($urandom), ($urandom % 5 == 0), 4'($urandom));
    $display("Test random done");
    nx(3);
    end_of_test();
  end
endmodule
